// *** include/rssf_pkg.sv ***
// Shared constants and types for the register select and status block
package rssf_pkg;

    // ==========================================
    // Register select codes
    localparam logic [5:0] SEL_STATUS = 6'h00;
    localparam logic [5:0] SEL_DATA = 6'h04;
    localparam logic [5:0] SEL_CHAN_BASE = 6'h10;
    localparam logic [5:0] SEL_SETUP_BASE = 6'h20;
    localparam logic [5:0] SEL_FILT_BASE = 6'h28;
    localparam logic [5:0] SEL_OFFS_BASE = 6'h30;
    localparam logic [5:0] SEL_GAIN_BASE = 6'h38;

    // ==========================================
    // Communications byte fields
    localparam int COMM_START_BIT = 7;
    localparam int COMM_READ_BIT = 6;

    // ==========================================
    // Status layout and reset
    localparam int STAT_READY_BIT = 7;
    localparam int STAT_RANGE_BIT = 6;
    localparam int STAT_CSUM_BIT = 5;
    localparam int STAT_INTEG_BIT = 4;
    localparam logic [7:0] STAT_RESET = 8'h80;
    localparam logic [23:0] RESULT_MAX = 24'hffffff;
    localparam logic [23:0] RESULT_MIN = 24'h000000;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        RSSF_IDLE = 2'b00,
        RSSF_CMD = 2'b01,
        RSSF_XFER = 2'b11
    } rssf_state_t;

    typedef enum logic [2:0] {
        RSSF_GRP_NONE = 3'h0,
        RSSF_GRP_CHAN = 3'h1,
        RSSF_GRP_SETUP = 3'h2,
        RSSF_GRP_FILT = 3'h3,
        RSSF_GRP_OFFS = 3'h4,
        RSSF_GRP_GAIN = 3'h5,
        RSSF_GRP_STATUS = 3'h6,
        RSSF_GRP_DATA = 3'h7
    } rssf_group_t;

    typedef struct packed {
        rssf_group_t group;
        logic [3:0] index;
    } rssf_sel_t;

    typedef struct packed {
        logic valid;
        logic over;
        logic under;
        logic calib;
        logic [3:0] chan;
        logic [23:0] value;
    } rssf_result_t;

    typedef struct packed {
        logic ready_n;
        logic range_err;
        logic csum_err;
        logic integ_err;
        logic [3:0] chan;
    } rssf_status_t;

    function automatic rssf_sel_t rssf_decode(input logic [5:0] code);
        rssf_sel_t s;
        s.index = {1'b0, code[2:0]};
        if (code[5:4] == SEL_CHAN_BASE[5:4]) begin
            s.group = RSSF_GRP_CHAN;
            s.index = code[3:0];
        end else if (code[5:3] == SEL_SETUP_BASE[5:3]) begin
            s.group = RSSF_GRP_SETUP;
        end else if (code[5:3] == SEL_FILT_BASE[5:3]) begin
            s.group = RSSF_GRP_FILT;
        end else if (code[5:3] == SEL_OFFS_BASE[5:3]) begin
            s.group = RSSF_GRP_OFFS;
        end else if (code[5:3] == SEL_GAIN_BASE[5:3]) begin
            s.group = RSSF_GRP_GAIN;
        end else if (code == SEL_STATUS) begin
            s.group = RSSF_GRP_STATUS;
        end else if (code == SEL_DATA) begin
            s.group = RSSF_GRP_DATA;
        end else begin
            s.group = RSSF_GRP_NONE;
        end
        return s;
    endfunction

endpackage

// *** hdl/rssf_sync.sv ***
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ns
`default_nettype none
module rssf_sync
    import rssf_pkg::*;
(
    // Clocking
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Pins
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_sync
);
    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } rssf_sync_st_t;

    rssf_sync_st_t st;
    rssf_sync_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.stage1 = pin_in;
        next_st.stage2 = st.stage1;
    end

    // Idle link levels: select, clock and data all high, so no false select
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{stage1: 3'b111, stage2: 3'b111};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stage2;
endmodule
`default_nettype wire

// *** hdl/rssf_status.sv ***
// Status byte: ready, range, checksum and integrity flags plus channel
`timescale 1ns/1ns
`default_nettype none
module rssf_status
    import rssf_pkg::*;
(
    // Clocking
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Events
    input wire rssf_result_t result,
    input wire logic data_read,
    input wire logic status_read,
    input wire logic csum_fail,
    input wire logic integ_enable,
    input wire logic integ_mismatch,
    // State out
    output rssf_status_t status,
    output logic [23:0] data_value
);
    typedef struct packed {
        rssf_status_t stat;
        logic [23:0] data;
    } rssf_stat_st_t;

    rssf_stat_st_t st;
    rssf_stat_st_t next_st;

    always_comb begin
        next_st = st;
        // Read first so a fresh result in the same cycle wins
        if (data_read) begin
            next_st.stat.ready_n = 1'b1;
        end
        if (result.valid) begin
            next_st.stat.ready_n = 1'b0;
            next_st.stat.range_err = result.over | result.under;
            if (!result.calib) begin
                next_st.stat.chan = result.chan;
                if (result.over) begin
                    next_st.data = RESULT_MAX;
                end else if (result.under) begin
                    next_st.data = RESULT_MIN;
                end else begin
                    next_st.data = result.value;
                end
            end
        end
        if (status_read) begin
            next_st.stat.csum_err = 1'b0;
        end
        if (csum_fail) begin
            next_st.stat.csum_err = 1'b1;
        end
        if (!integ_enable) begin
            next_st.stat.integ_err = 1'b0;
        end else if (integ_mismatch) begin
            next_st.stat.integ_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{stat: STAT_RESET, data: RESULT_MIN};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign status = st.stat;
    assign data_value = st.data;

    property p_csum_set;
        @(posedge core_clk) disable iff (rst)
        (clk_en && csum_fail) |=> status.csum_err;
    endproperty
    a_csum_set: assert property (p_csum_set) else $error("checksum flag not set");

    property p_csum_clear;
        @(posedge core_clk) disable iff (rst)
        (clk_en && status_read && !csum_fail) |=> !status.csum_err;
    endproperty
    a_csum_clear: assert property (p_csum_clear) else $error("checksum flag not cleared");

    property p_integ_hold;
        @(posedge core_clk) disable iff (rst)
        (status.integ_err && integ_enable) |=> status.integ_err;
    endproperty
    a_integ_hold: assert property (p_integ_hold) else $error("integrity flag dropped");

    property p_integ_clear;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !integ_enable) |=> !status.integ_err;
    endproperty
    a_integ_clear: assert property (p_integ_clear) else $error("integrity flag stuck");

    property p_integ_set;
        @(posedge core_clk) disable iff (rst)
        (clk_en && integ_enable && integ_mismatch) |=> status.integ_err;
    endproperty
    a_integ_set: assert property (p_integ_set) else $error("integrity flag not set");

    property p_ready_low;
        @(posedge core_clk) disable iff (rst)
        (clk_en && result.valid) |=> !status.ready_n;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready not cleared on result");

    property p_range_hold;
        @(posedge core_clk) disable iff (rst)
        !(clk_en && result.valid) |=> $stable(status.range_err);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range flag moved");

    property p_clamp;
        @(posedge core_clk) disable iff (rst)
        (clk_en && result.valid && result.over && !result.calib)
            |=> (data_value == RESULT_MAX) && status.range_err;
    endproperty
    a_clamp: assert property (p_clamp) else $error("overrange not clamped");
endmodule
`default_nettype wire

// *** hdl/rssf_regsel.sv ***
// Serial command decode, register select and status reporting
`timescale 1ns/1ns
`default_nettype none
// ==========================================
module rssf_regsel
    import rssf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Serial link pins
    input wire logic sel_n,
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    output logic link_dout_oe,
    // Conversion engine side
    input wire rssf_result_t result,
    input wire logic append_status,
    input wire logic integ_enable,
    input wire logic integ_mismatch,
    input wire logic [23:0] reg_rdata,
    input wire logic [4:0] reg_rlen,
    // Register access toward the rest of the device
    output rssf_sel_t target_sel,
    output logic reg_read,
    output logic reg_write,
    output logic [23:0] reg_wdata,
    input wire logic [4:0] reg_wlen,
    input wire logic reg_wcsum_bad,
    // Status view
    output rssf_status_t status
);
    typedef struct packed {
        rssf_state_t fsm;
        logic is_read;
        logic [5:0] target_select_code;
        logic [31:0] shift;
        logic [5:0] bits_left;
        logic [7:0] cmd;
        logic [3:0] cmd_cnt;
        logic prev_clk;
        logic dout;
        logic rd_pulse;
        logic wr_pulse;
        logic [23:0] wdata;
    } rssf_st_t;

    rssf_st_t st;
    rssf_st_t next_st;
    logic [2:0] pins;
    logic sel_n_s;
    logic clk_s;
    logic din_s;
    logic rise;
    logic fall;
    logic data_read;
    logic status_read;
    logic [23:0] data_value;
    rssf_sel_t dec;
    logic [31:0] load_word;
    logic [5:0] load_len;

    // ==========================================
    // Pin synchronisation
    rssf_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in({sel_n, link_clk, link_din}),
        .pin_sync(pins)
    );

    assign sel_n_s = pins[2];
    assign clk_s = pins[1];
    assign din_s = pins[0];
    // Link clock idles high: shift out on falls, sample on rises
    assign rise = clk_s && !st.prev_clk;
    assign fall = !clk_s && st.prev_clk;

    // ==========================================
    // Status byte
    rssf_status u_status (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .result(result),
        .data_read(data_read),
        .status_read(status_read),
        .csum_fail(reg_write && reg_wcsum_bad),
        .integ_enable(integ_enable),
        .integ_mismatch(integ_mismatch),
        .status(status),
        .data_value(data_value)
    );

    // ==========================================
    // Read word assembly
    assign dec = rssf_decode(st.target_select_code);

    always_comb begin
        load_word = 32'h0000_0000;
        load_len = 6'h00;
        case (dec.group)
            RSSF_GRP_STATUS: begin
                load_word = {status, 24'h000000};
                load_len = 6'h08;
            end
            RSSF_GRP_DATA: begin
                if (append_status) begin
                    load_word = {data_value, status};
                    load_len = 6'h20;
                end else begin
                    load_word = {data_value, 8'h00};
                    load_len = 6'h18;
                end
            end
            RSSF_GRP_NONE: begin
                load_word = 32'h0000_0000;
                load_len = 6'h08;
            end
            default: begin
                load_word = {reg_rdata << (5'd24 - reg_rlen), 8'h00};
                load_len = {1'b0, reg_rlen};
            end
        endcase
    end

    assign data_read = st.rd_pulse && dec.group == RSSF_GRP_DATA;
    assign status_read = st.rd_pulse && dec.group == RSSF_GRP_STATUS;

    // ==========================================
    // Transaction state
    always_comb begin
        next_st = st;
        next_st.prev_clk = clk_s;
        next_st.rd_pulse = 1'b0;
        next_st.wr_pulse = 1'b0;
        if (sel_n_s) begin
            // Deselect aborts any frame; the next one begins with a command
            next_st.fsm = RSSF_IDLE;
            next_st.cmd_cnt = BIT_CNT_RESET;
        end else begin
            case (st.fsm)
                RSSF_IDLE: begin
                    next_st.fsm = RSSF_CMD;
                    next_st.cmd_cnt = BIT_CNT_RESET;
                end
                RSSF_CMD: begin
                    if (rise) begin
                        next_st.cmd = {st.cmd[6:0], din_s};
                        next_st.cmd_cnt = st.cmd_cnt + 4'h1;
                        if (st.cmd_cnt == 4'h0 && din_s) begin
                            // Start bit must be zero; stay waiting
                            next_st.cmd_cnt = BIT_CNT_RESET;
                        end else if (st.cmd_cnt == 4'h7) begin
                            next_st.target_select_code = {st.cmd[4:0], din_s};
                            next_st.is_read = st.cmd[5];
                            next_st.fsm = RSSF_XFER;
                            next_st.cmd_cnt = BIT_CNT_RESET;
                            next_st.bits_left = 6'h00;
                            next_st.wdata = 24'h000000;
                        end
                    end
                end
                RSSF_XFER: begin
                    if (st.is_read) begin
                        if (st.bits_left == 6'h00 && st.cmd_cnt == 4'h0) begin
                            next_st.shift = load_word;
                            next_st.bits_left = load_len;
                            next_st.cmd_cnt = 4'h1;
                            next_st.rd_pulse = 1'b1;
                            next_st.dout = load_word[31];
                        end else if (fall && st.bits_left != 6'h00) begin
                            next_st.shift = {st.shift[30:0], 1'b0};
                            next_st.dout = st.shift[30];
                        end
                        if (rise && st.bits_left != 6'h00) begin
                            next_st.bits_left = st.bits_left - 6'h01;
                            if (st.bits_left == 6'h01) begin
                                next_st.fsm = RSSF_CMD;
                                next_st.cmd_cnt = BIT_CNT_RESET;
                            end
                        end
                    end else if (rise) begin
                        next_st.wdata = {st.wdata[22:0], din_s};
                        next_st.bits_left = st.bits_left + 6'h01;
                        if (st.bits_left + 6'h01 == {1'b0, reg_wlen}) begin
                            next_st.wr_pulse = dec.group != RSSF_GRP_NONE;
                            next_st.fsm = RSSF_CMD;
                            next_st.cmd_cnt = BIT_CNT_RESET;
                        end
                    end
                end
                default: begin
                    next_st.fsm = RSSF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{fsm: RSSF_IDLE, prev_clk: 1'b1, default: '0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs
    // Ready shows on the shared pin whenever selected and not mid-read
    assign link_dout_oe = !sel_n_s;
    assign link_dout = (st.fsm == RSSF_XFER && st.is_read) ? st.dout
                                                           : status.ready_n;
    assign target_sel = dec;
    assign reg_read = st.rd_pulse;
    assign reg_write = st.wr_pulse && clk_en;
    assign reg_wdata = st.wdata;

    // ==========================================
    // Checks
    sequence s_selected_idle;
        !sel_n_s && !(st.fsm == RSSF_XFER && st.is_read);
    endsequence

    property p_ready_pin;
        @(posedge core_clk) disable iff (rst)
        s_selected_idle |-> link_dout_oe && (link_dout == status.ready_n);
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready not on pin");

    property p_data_read_ready;
        @(posedge core_clk) disable iff (rst)
        (clk_en && data_read && !result.valid) |=> status.ready_n;
    endproperty
    a_data_read_ready: assert property (p_data_read_ready) else $error("ready not raised");

    property p_status_reset;
        @(posedge core_clk) $fell(rst) |-> status == STAT_RESET;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("bad status reset");

    property p_unmapped_write;
        @(posedge core_clk) disable iff (rst)
        dec.group == RSSF_GRP_NONE |-> !reg_write;
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write");

    property p_append;
        @(posedge core_clk) disable iff (rst)
        (clk_en && data_read && append_status) |-> st.bits_left == 6'h20;
    endproperty
    a_append: assert property (p_append) else $error("status not appended");

    property p_gain_decode;
        @(posedge core_clk) disable iff (rst)
        st.target_select_code[5:3] == 3'h7
            |-> dec.group == RSSF_GRP_GAIN && dec.index == {1'b0, st.target_select_code[2:0]};
    endproperty
    a_gain_decode: assert property (p_gain_decode) else $error("gain decode");

    property p_chan_decode;
        @(posedge core_clk) disable iff (rst)
        st.target_select_code[5:4] == 2'h1
            |-> dec.group == RSSF_GRP_CHAN && dec.index == st.target_select_code[3:0];
    endproperty
    a_chan_decode: assert property (p_chan_decode) else $error("channel decode");

    property p_setup_decode;
        @(posedge core_clk) disable iff (rst)
        st.target_select_code[5:3] == 3'h4
            |-> dec.group == RSSF_GRP_SETUP && dec.index == {1'b0, st.target_select_code[2:0]};
    endproperty
    a_setup_decode: assert property (p_setup_decode) else $error("setup decode");

    property p_filt_decode;
        @(posedge core_clk) disable iff (rst)
        st.target_select_code[5:3] == 3'h5
            |-> dec.group == RSSF_GRP_FILT && dec.index == {1'b0, st.target_select_code[2:0]};
    endproperty
    a_filt_decode: assert property (p_filt_decode) else $error("filter decode");

    property p_offs_decode;
        @(posedge core_clk) disable iff (rst)
        st.target_select_code[5:3] == 3'h6
            |-> dec.group == RSSF_GRP_OFFS && dec.index == {1'b0, st.target_select_code[2:0]};
    endproperty
    a_offs_decode: assert property (p_offs_decode) else $error("offset decode");

    // Last command bit taken on this edge
    sequence s_cmd_last;
        clk_en && !sel_n_s && st.fsm == RSSF_CMD && rise && st.cmd_cnt == 4'h7;
    endsequence

    property p_cmd_code;
        @(posedge core_clk) disable iff (rst)
        s_cmd_last |=> st.target_select_code == {$past(st.cmd[4:0]), $past(din_s)};
    endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("select code not latched");

    property p_cmd_dir;
        @(posedge core_clk) disable iff (rst)
        s_cmd_last |=> st.fsm == RSSF_XFER && st.is_read == $past(st.cmd[5]);
    endproperty
    a_cmd_dir: assert property (p_cmd_dir) else $error("direction not latched");

    property p_start_bit;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !sel_n_s && st.fsm == RSSF_CMD && rise && st.cmd_cnt == 4'h0 && din_s)
            |=> st.fsm == RSSF_CMD && st.cmd_cnt == BIT_CNT_RESET;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not refused");

    property p_abort;
        @(posedge core_clk) disable iff (rst)
        (clk_en && sel_n_s) |=> st.fsm == RSSF_IDLE && !reg_write;
    endproperty
    a_abort: assert property (p_abort) else $error("frame not aborted");

    property p_unmapped_read;
        @(posedge core_clk) disable iff (rst)
        (st.rd_pulse && dec.group == RSSF_GRP_NONE)
            |-> st.shift == 32'h0000_0000 && st.bits_left == 6'h08;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");
endmodule
`default_nettype wire

// *** tb/rssf_host.sv ***
// Host controller model for the serial register link
`timescale 1ns/1ns
`default_nettype none
module rssf_host (
    // Link pins
    output logic sel_n,
    output logic link_clk,
    output logic link_din,
    input wire logic link_dout
);
    // ==========================================
    // Idle link
    initial begin
        sel_n = 1'b1;
        link_clk = 1'b1;
        link_din = 1'b1;
    end

    // ==========================================
    // One framed access
    // Command byte first, then payload, MSB first
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                        output logic [31:0] rd);
        rd = '0;
        sel_n = 1'b0;
        // Extra 2 ns keeps every link edge but the select fall off both core clock edges
        #102;
        for (int i = 0; i < 8 + n; i++) begin
            // Read bits sampled late in the high phase, before the shifting fall
            if (i >= 8 && cmd[6])
                rd = {rd[30:0], link_dout};
            link_clk = 1'b0;
            // Unused input line toggles so a stale level is never trusted
            link_din = (i < 8) ? cmd[7 - i] : (cmd[6] ? ~link_din : wd[n + 7 - i]);
            #62 link_clk = 1'b1;
            #63;
            if (i == 7)
                #200;
        end
        // Any read checksum would be judged here, not by the device
        #100 sel_n = 1'b1;
        link_din = ~link_din;
        #198;
    endtask

    task automatic hold_sel(input logic v);
        sel_n = v;
    endtask
endmodule
`default_nettype wire

// *** tb/register_select_and_status_flags_tb.sv ***
// Self-checking bench for the register select and status block
`timescale 1ns/1ns
`default_nettype none
module register_select_and_status_flags_tb;
    import rssf_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic sel_n, link_clk, link_din, link_dout, link_dout_oe;
    rssf_result_t result = '0;
    logic append_status = 1'b0;
    logic integ_enable = 1'b0;
    logic integ_mismatch = 1'b0;
    logic [23:0] reg_rdata = 24'h000000;
    logic reg_wcsum_bad = 1'b0;
    rssf_sel_t target_sel, wr_sel;
    logic reg_read, reg_write;
    logic [23:0] reg_wdata, wr_data;
    rssf_status_t status;
    logic [31:0] rd;
    logic [15:0] rnd = 16'h0003;
    logic [5:0] code;
    logic [5:0] corner [10] = '{6'h10, 6'h1f, 6'h20, 6'h27, 6'h28, 6'h2f, 6'h30, 6'h37, 6'h38,
                                6'h3f};
    int err_count = 0;
    int check_count = 0;
    int wr_n = 0;
    int rd_n = 0;
    int n0;

    always #5 core_clk = ~core_clk;

    rssf_regsel i_rssf_regsel (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .sel_n(sel_n), .link_clk(link_clk), .link_din(link_din), .link_dout(link_dout),
        .link_dout_oe(link_dout_oe), .result(result), .append_status(append_status),
        .integ_enable(integ_enable), .integ_mismatch(integ_mismatch),
        .reg_rdata(reg_rdata), .reg_rlen(5'h18), .target_sel(target_sel),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_wlen(5'h08), .reg_wcsum_bad(reg_wcsum_bad), .status(status));
    rssf_host i_rssf_host (.sel_n(sel_n), .link_clk(link_clk), .link_din(link_din),
        .link_dout(link_dout));

    always @(posedge core_clk) begin
        if (reg_read) begin
            rd_n <= rd_n + 1;
        end
        if (reg_write) begin
            wr_n <= wr_n + 1;
            wr_sel <= target_sel;
            wr_data <= reg_wdata;
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic rssf_sel_t exp_sel(input logic [5:0] c);
        rssf_sel_t s;
        s.index = {1'b0, c[2:0]};
        case (c[5:3])
            3'h2, 3'h3: begin
                s.group = RSSF_GRP_CHAN;
                s.index = c[3:0];
            end
            3'h4: s.group = RSSF_GRP_SETUP;
            3'h5: s.group = RSSF_GRP_FILT;
            3'h6: s.group = RSSF_GRP_OFFS;
            default: s.group = RSSF_GRP_GAIN;
        endcase
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic ov, input logic un, input logic cal, input logic [3:0] ch);
        @(negedge core_clk);
        rnd = lfsr(rnd);
        result = '{1'b1, ov, un, cal, ch, {rnd, rnd[7:0]}};
        @(negedge core_clk);
        result.valid = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic close_out;
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_count++;
        close_out;
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        chk({24'h0, status}, 32'h80);
        i_rssf_host.xfer(8'h40, 8, 0, rd);
        chk(rd, 32'h80);
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            code = (i < 10) ? corner[i] : 6'h08 + 6'(rnd % 56);
            n0 = wr_n;
            i_rssf_host.xfer({2'b00, code}, 8, {24'h0, rnd[15:8]}, rd);
            chk(wr_n - n0, (code >= 6'h10) ? 1 : 0);
            if (code >= 6'h10) begin
                chk({25'h0, wr_sel}, {25'h0, exp_sel(code)});
                chk({24'h0, wr_data[7:0]}, {24'h0, rnd[15:8]});
            end
        end
        put(1'b1, 1'b0, 1'b0, 4'h5);
        chk({24'h0, status}, 32'h45);
        i_rssf_host.hold_sel(1'b0);
        repeat (6) @(negedge core_clk);
        chk({30'h0, link_dout_oe, link_dout}, {30'h0, 1'b1, 1'b0});
        i_rssf_host.hold_sel(1'b1);
        repeat (4) @(negedge core_clk);
        append_status = 1'b1;
        i_rssf_host.xfer(8'h44, 32, 0, rd);
        chk({8'h0, rd[31:8]}, 32'hffffff);
        chk({25'h0, rd[6:0]}, 32'h45);
        chk({31'h0, status.ready_n}, 32'h1);
        put(1'b0, 1'b0, 1'b0, 4'h9);
        chk({24'h0, status}, 32'h09);
        put(1'b0, 1'b1, 1'b0, 4'h2);
        append_status = 1'b0;
        i_rssf_host.xfer(8'h44, 24, 0, rd);
        chk(rd, 32'h0);
        put(1'b0, 1'b0, 1'b1, 4'hc);
        chk({27'h0, status.ready_n, status.chan}, 32'h02);
        reg_wcsum_bad = 1'b1;
        i_rssf_host.xfer(8'h10, 8, 32'h5a, rd);
        reg_wcsum_bad = 1'b0;
        chk({31'h0, status.csum_err}, 32'h1);
        i_rssf_host.xfer(8'h40, 8, 0, rd);
        chk({31'h0, rd[5]}, 32'h1);
        chk({31'h0, status.csum_err}, 32'h0);
        reg_rdata = 24'ha5c3e1;
        i_rssf_host.xfer(8'h49, 8, 0, rd);
        chk(rd, 32'h0);
        n0 = rd_n;
        i_rssf_host.xfer(8'h78, 24, 0, rd);
        chk(rd, 32'ha5c3e1);
        chk(rd_n - n0, 1);
        chk({25'h0, target_sel}, {25'h0, exp_sel(6'h38)});
        integ_enable = 1'b1;
        integ_mismatch = 1'b1;
        repeat (3) @(negedge core_clk);
        integ_mismatch = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({31'h0, status.integ_err}, 32'h1);
        integ_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({31'h0, status.integ_err}, 32'h0);
        clk_en = 1'b0;
        put(1'b1, 1'b0, 1'b0, 4'h7);
        chk({24'h0, status}, 32'h02);
        clk_en = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({24'h0, status}, 32'h02);
        close_out;
    end
endmodule
`default_nettype wire
